// ===== common/pcg_params.svh
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// Register byte offsets
`define PCG_OFS_RUN_GATE 12'h108
`define PCG_OFS_SLEEP_GATE 12'h118
`define PCG_OFS_DEEP_GATE 12'h128
`define PCG_OFS_RUN_CFG 12'h200
`define PCG_OFS_IRQ_STATUS 12'h204
`define PCG_OFS_IRQ_MASK 12'h208

// Field layout
`define PCG_NUM_PORTS 5
`define PCG_PORT_MSB 4
`define PCG_AUTO_GATE_BIT 0
`define PCG_WORD_LSB 2
`define PCG_STRB_LANE0 0

// Reset values
`define PCG_GATE_RESET 5'h00
`define PCG_CFG_RESET 1'b0
`define PCG_MASK_RESET 5'h00
`define PCG_WORD_ZERO 32'h0000_0000

// AXI responses
`define PCG_RESP_OKAY 2'b00
`define PCG_RESP_SLVERR 2'b10

`endif

// ===== common/pcg_pkg.sv
`default_nettype none

package pcg_pkg;

  typedef enum logic {
    PCG_RD_IDLE,
    PCG_RD_DATA
  } pcg_rd_state_type;

  typedef logic [4:0] pcg_port_mask_type;

endpackage : pcg_pkg

`default_nettype wire

// ===== logic/pcg_top.sv
`include "pcg_params.svh"
`default_nettype none

module pcg_top
  import pcg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NPORT = `PCG_NUM_PORTS
) (
  input wire logic CLK, // System clock, 250 MHz
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] AWADDR, // Write address
  input wire logic [2:0] AWPROT, // Write protection, unused
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write byte strobes
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  output logic [1:0] BRESP, // Write response
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  input wire logic [ADDR_W-1:0] ARADDR, // Read address
  input wire logic [2:0] ARPROT, // Read protection, unused
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  output logic RVALID, // Read data valid
  input wire logic RREADY, // Read data ready
  input wire logic SLEEP_MODE, // System is in sleep
  input wire logic DEEP_SLEEP_MODE, // System is in deep sleep
  input wire logic [NPORT-1:0] PORT_ACCESS, // Pulse: bus access aimed at a port
  output logic [NPORT-1:0] PORT_CLK_EN, // Clock enable per port
  output logic [NPORT-1:0] PORT_BUS_FAULT, // Pulse: access to gated port faulted
  output logic IRQ // Level interrupt
);

  // Register storage
  logic [NPORT-1:0] run_gate_r;
  logic [NPORT-1:0] run_gate_nxt;
  logic [NPORT-1:0] sleep_gate_r;
  logic [NPORT-1:0] sleep_gate_nxt;
  logic [NPORT-1:0] deep_gate_r;
  logic [NPORT-1:0] deep_gate_nxt;
  logic auto_gating_select_r;
  logic auto_gating_select_nxt;

  // Interrupt mask and sticky fault status
  logic [NPORT-1:0] irq_mask_r;
  logic [NPORT-1:0] irq_mask_nxt;
  logic [NPORT-1:0] irq_status_r;
  logic [NPORT-1:0] irq_status_nxt;

  // Port gating
  logic [NPORT-1:0] clk_en_r;
  logic [NPORT-1:0] clk_en_nxt;
  logic [NPORT-1:0] fault_r;
  logic [NPORT-1:0] fault_nxt;
  logic [NPORT-1:0] gate_sel;

  // Write channel
  logic aw_full_r;
  logic aw_full_nxt;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [ADDR_W-1:0] aw_addr_nxt;
  logic w_full_r;
  logic w_full_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0] w_strb_r;
  logic [3:0] w_strb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;

  // Write decode
  logic do_write;
  logic wr_hit;
  logic [ADDR_W-1:0] wr_word;
  logic lane0;

  // Read channel
  pcg_rd_state_type rd_state_r;
  pcg_rd_state_type rd_state_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic rd_take;
  logic [ADDR_W-1:0] rd_word;
  logic status_rd_clear;

  // Word-aligned addresses: byte offset bits are ignored
  assign wr_word = {aw_addr_r[ADDR_W-1:`PCG_WORD_LSB], 2'b00};
  assign rd_word = {ARADDR[ADDR_W-1:`PCG_WORD_LSB], 2'b00};
  assign lane0 = w_strb_r[`PCG_STRB_LANE0];

  // Write channel
  // Address and data are held apart so either may come first; the write
  // lands and the response rises in the cycle after both are held.
  // Nothing new is taken while a response waits for its handshake.
  assign AWREADY = !aw_full_r && !bvalid_r;
  assign WREADY = !w_full_r && !bvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign do_write = aw_full_r && w_full_r && !bvalid_r;

  // Unmapped words answer with a slave error and change nothing
  always_comb begin
    wr_hit = 1'b0;
    if (wr_word == `PCG_OFS_RUN_GATE) begin
      wr_hit = 1'b1;
    end else if (wr_word == `PCG_OFS_SLEEP_GATE) begin
      wr_hit = 1'b1;
    end else if (wr_word == `PCG_OFS_DEEP_GATE) begin
      wr_hit = 1'b1;
    end else if (wr_word == `PCG_OFS_RUN_CFG) begin
      wr_hit = 1'b1;
    end else if (wr_word == `PCG_OFS_IRQ_STATUS) begin
      wr_hit = 1'b1;
    end else if (wr_word == `PCG_OFS_IRQ_MASK) begin
      wr_hit = 1'b1;
    end
  end

  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (AWVALID && AWREADY) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_full_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB;
    end
    // Both halves held: release them and raise the response
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (wr_hit) begin
        bresp_nxt = `PCG_RESP_OKAY;
      end else begin
        bresp_nxt = `PCG_RESP_SLVERR;
      end
    end else if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_full_r <= 1'b0;
      w_data_r <= `PCG_WORD_ZERO;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `PCG_RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r <= w_full_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // Register file
  // Only byte lane 0 carries live bits; upper bits are dropped on write.
  // A write to the status word is answered but changes nothing.
  always_comb begin
    run_gate_nxt = run_gate_r;
    sleep_gate_nxt = sleep_gate_r;
    deep_gate_nxt = deep_gate_r;
    auto_gating_select_nxt = auto_gating_select_r;
    irq_mask_nxt = irq_mask_r;
    if (do_write && lane0) begin
      if (wr_word == `PCG_OFS_RUN_GATE) begin
        run_gate_nxt = w_data_r[`PCG_PORT_MSB:0];
      end else if (wr_word == `PCG_OFS_SLEEP_GATE) begin
        sleep_gate_nxt = w_data_r[`PCG_PORT_MSB:0];
      end else if (wr_word == `PCG_OFS_DEEP_GATE) begin
        deep_gate_nxt = w_data_r[`PCG_PORT_MSB:0];
      end else if (wr_word == `PCG_OFS_RUN_CFG) begin
        auto_gating_select_nxt = w_data_r[`PCG_AUTO_GATE_BIT];
      end else if (wr_word == `PCG_OFS_IRQ_MASK) begin
        irq_mask_nxt = w_data_r[`PCG_PORT_MSB:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_gate_r <= `PCG_GATE_RESET;
      sleep_gate_r <= `PCG_GATE_RESET;
      deep_gate_r <= `PCG_GATE_RESET;
      auto_gating_select_r <= `PCG_CFG_RESET;
      irq_mask_r <= `PCG_MASK_RESET;
    end else begin
      run_gate_r <= run_gate_nxt;
      sleep_gate_r <= sleep_gate_nxt;
      deep_gate_r <= deep_gate_nxt;
      auto_gating_select_r <= auto_gating_select_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Read channel
  // A status read clears the sticky bits at the address handshake; the
  // returned word still holds the bits that were set before it.
  assign ARREADY = (rd_state_r == PCG_RD_IDLE);
  assign RVALID = (rd_state_r == PCG_RD_DATA);
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign rd_take = ARVALID && ARREADY;
  assign status_rd_clear = rd_take && (rd_word == `PCG_OFS_IRQ_STATUS);

  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_state_r)
      PCG_RD_IDLE: begin
        if (rd_take) begin
          rd_state_nxt = PCG_RD_DATA;
          rdata_nxt = `PCG_WORD_ZERO;
          rresp_nxt = `PCG_RESP_OKAY;
          if (rd_word == `PCG_OFS_RUN_GATE) begin
            rdata_nxt[`PCG_PORT_MSB:0] = run_gate_r;
          end else if (rd_word == `PCG_OFS_SLEEP_GATE) begin
            rdata_nxt[`PCG_PORT_MSB:0] = sleep_gate_r;
          end else if (rd_word == `PCG_OFS_DEEP_GATE) begin
            rdata_nxt[`PCG_PORT_MSB:0] = deep_gate_r;
          end else if (rd_word == `PCG_OFS_RUN_CFG) begin
            rdata_nxt[`PCG_AUTO_GATE_BIT] = auto_gating_select_r;
          end else if (rd_word == `PCG_OFS_IRQ_STATUS) begin
            rdata_nxt[`PCG_PORT_MSB:0] = irq_status_r;
          end else if (rd_word == `PCG_OFS_IRQ_MASK) begin
            rdata_nxt[`PCG_PORT_MSB:0] = irq_mask_r;
          end else begin
            rresp_nxt = `PCG_RESP_SLVERR;
          end
        end
      end
      PCG_RD_DATA: begin
        if (RREADY) begin
          rd_state_nxt = PCG_RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = PCG_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_state_r <= PCG_RD_IDLE;
      rdata_r <= `PCG_WORD_ZERO;
      rresp_r <= `PCG_RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Port clock gating
  // Sleep settings count only with auto gating on; without it the run
  // register governs every mode. Deep sleep outranks sleep.
  always_comb begin
    gate_sel = run_gate_r;
    if (auto_gating_select_r) begin
      if (DEEP_SLEEP_MODE) begin
        gate_sel = deep_gate_r;
      end else if (SLEEP_MODE) begin
        gate_sel = sleep_gate_r;
      end
    end
  end

  // Enables are registered so a port gate never sees a decode glitch
  assign PORT_CLK_EN = clk_en_r;
  assign PORT_BUS_FAULT = fault_r;
  // Level interrupt: high while any unmasked fault bit is set
  assign IRQ = |(irq_status_r & irq_mask_r);

  genvar gi;
  generate
    // One enable, fault and status bit per port
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      always_comb begin
        clk_en_nxt[gi] = gate_sel[gi];
        // The fault test uses the enable the port sees in this cycle
        fault_nxt[gi] = PORT_ACCESS[gi] && !clk_en_r[gi];
        // A new fault wins over a status read in the same cycle
        if (fault_nxt[gi]) begin
          irq_status_nxt[gi] = 1'b1;
        end else if (status_rd_clear) begin
          irq_status_nxt[gi] = 1'b0;
        end else begin
          irq_status_nxt[gi] = irq_status_r[gi];
        end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          clk_en_r[gi] <= 1'b0;
          fault_r[gi] <= 1'b0;
          irq_status_r[gi] <= 1'b0;
        end else begin
          clk_en_r[gi] <= clk_en_nxt[gi];
          fault_r[gi] <= fault_nxt[gi];
          irq_status_r[gi] <= irq_status_nxt[gi];
        end
      end
    end
  endgenerate

endmodule : pcg_top

`default_nettype wire

// ===== testbench/pcg_checker.sv
`default_nettype none
module pcg_checker #(
  parameter int NPORT = 5
) (
  input wire logic CLK, // Clock
  input wire logic RST_B, // Reset
  input wire logic BVALID, // Write resp
  input wire logic ARVALID, // Read addr
  input wire logic ARREADY, // Read ready
  input wire logic RVALID, // Read valid
  input wire logic [31:0] RDATA, // Read data
  input wire logic SLEEP_MODE, // Sleep
  input wire logic DEEP_SLEEP_MODE, // Deep sleep
  input wire logic [NPORT-1:0] PORT_ACCESS, // Access
  input wire logic [NPORT-1:0] PORT_CLK_EN, // Enable
  input wire logic [NPORT-1:0] PORT_BUS_FAULT, // Fault
  input wire logic IRQ // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_RST_EN: assert property ($rose(RST_B) |-> PORT_CLK_EN == '0 && !IRQ)
    else $error("Enable or interrupt set after reset");
  AST_RST_FAULT: assert property ($rose(RST_B) |-> PORT_BUS_FAULT == '0)
    else $error("Fault after reset");
  AST_FAULT_MAP: assert property (PORT_BUS_FAULT == ($past(PORT_ACCESS) & ~$past(PORT_CLK_EN)))
    else $error("Fault does not match gated access");
  AST_NO_FAULT_EN: assert property ((PORT_BUS_FAULT & $past(PORT_CLK_EN)) == '0)
    else $error("Fault on clocked port");
  AST_FAULT_PULSE: assert property ((|(PORT_ACCESS & ~PORT_CLK_EN)) ##1 (PORT_ACCESS == '0)
    |=> PORT_BUS_FAULT == '0) else $error("Fault longer than access");
  AST_EN_CAUSE: assert property ($changed(PORT_CLK_EN) |-> $past(BVALID)
    || $past(SLEEP_MODE) != $past(SLEEP_MODE, 2)
    || $past(DEEP_SLEEP_MODE) != $past(DEEP_SLEEP_MODE, 2)) else $error("Enable changed alone");
  AST_HI_ZERO: assert property (RVALID |-> RDATA[31:5] == 27'h000_0000)
    else $error("Upper read bits set");
  AST_RD_LAT: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("Read answer late");
endmodule : pcg_checker

bind pcg_top pcg_checker #(.NPORT(NPORT)) u_pcg_checker (
  .CLK(CLK), .RST_B(RST_B), .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RVALID(RVALID), .RDATA(RDATA), .SLEEP_MODE(SLEEP_MODE),
  .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .PORT_ACCESS(PORT_ACCESS),
  .PORT_CLK_EN(PORT_CLK_EN), .PORT_BUS_FAULT(PORT_BUS_FAULT), .IRQ(IRQ)
);
`default_nettype wire

// ===== testbench/pcg_tb_top.sv
`default_nettype none
module pcg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP_MODE, DEEP_SLEEP_MODE;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, r;
  logic [4:0] PORT_ACCESS, PORT_CLK_EN, PORT_BUS_FAULT;
  int failures, num_checks;

  pcg_top u_pcg_top (
    .CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .SLEEP_MODE(SLEEP_MODE), .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE),
    .PORT_ACCESS(PORT_ACCESS), .PORT_CLK_EN(PORT_CLK_EN),
    .PORT_BUS_FAULT(PORT_BUS_FAULT), .IRQ(IRQ)
  );

  always #2 CLK = ~CLK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (AWVALID || WVALID || !BVALID);
    r = BRESP;
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (ARVALID || !RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask : rd

  task automatic mode(input logic s, input logic dp, input logic [4:0] e);
    @(posedge CLK);
    SLEEP_MODE <= s;
    DEEP_SLEEP_MODE <= dp;
    @(posedge CLK);
    #1 chk(PORT_CLK_EN, e);
  endtask : mode

  task automatic t_reset;
    logic [11:0] regs [6];
    regs = '{12'h108, 12'h118, 12'h128, 12'h200, 12'h204, 12'h208};
    chk(PORT_CLK_EN, 32'h0000_0000);
    chk(PORT_BUS_FAULT, 32'h0000_0000);
    chk(IRQ, 1'b0);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(d, 32'h0000_0000);
    end
  endtask : t_reset

  task automatic t_regs;
    wr(12'h108, 32'hFFFF_FFFF);
    chk(r, 2'b00);
    #1 chk(PORT_CLK_EN, 32'h0000_001F);
    rd(12'h108);
    chk(d, 32'h0000_001F);
    chk(r, 2'b00);
    wr(12'h118, 32'hFFFF_FFE4);
    rd(12'h118);
    chk(d, 32'h0000_0004);
    WSTRB <= 4'hE;
    wr(12'h118, 32'h0000_001F);
    WSTRB <= 4'hF;
    rd(12'h118);
    chk(d, 32'h0000_0004);
    wr(12'h10C, 32'h0000_001F);
    chk(r, 2'b10);
    rd(12'h10C);
    chk(r, 2'b10);
    wr(12'h204, 32'h0000_001F);
    rd(12'h204);
    chk(d, 32'h0000_0000);
  endtask : t_regs

  task automatic t_fault;
    wr(12'h108, 32'h0000_000A);
    #1 chk(PORT_CLK_EN, 32'h0000_000A);
    wr(12'h208, 32'h0000_0001);
    @(posedge CLK);
    PORT_ACCESS <= 5'h1F;
    @(posedge CLK);
    PORT_ACCESS <= 5'h00;
    #1 chk(PORT_BUS_FAULT, 32'h0000_0015);
    chk(IRQ, 1'b1);
    wr(12'h208, 32'h0000_0000);
    #1 chk(IRQ, 1'b0);
    rd(12'h204);
    chk(d, 32'h0000_0015);
    wr(12'h208, 32'h0000_0001);
    #1 chk(IRQ, 1'b0);
  endtask : t_fault

  task automatic t_modes;
    wr(12'h118, 32'h0000_0011);
    wr(12'h128, 32'h0000_0006);
    mode(1'b0, 1'b1, 5'h0A);
    mode(1'b1, 1'b0, 5'h0A);
    wr(12'h200, 32'h0000_0001);
    #1 chk(PORT_CLK_EN, 32'h0000_0011);
    rd(12'h200);
    chk(d, 32'h0000_0001);
    mode(1'b1, 1'b1, 5'h06);
    mode(1'b0, 1'b0, 5'h0A);
  endtask : t_modes

  task automatic t_rerst;
    @(posedge CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk(PORT_CLK_EN, 32'h0000_0000);
    @(posedge CLK);
    RST_B <= 1'b1;
    t_reset();
  endtask : t_rerst

  task automatic test_done;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    CLK = 1'b0;
    RST_B = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP_MODE, DEEP_SLEEP_MODE} = 7'h00;
    AWADDR = 12'h000;
    ARADDR = 12'h000;
    WDATA = 32'h0000_0000;
    WSTRB = 4'hF;
    PORT_ACCESS = 5'h00;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    t_reset();
    t_regs();
    t_fault();
    t_modes();
    t_rerst();
    test_done();
  end

  // Cuts a hang well past the expected 130 or so cycles
  initial begin
    repeat (5000) @(posedge CLK);
    failures++;
    test_done();
  end
endmodule : pcg_tb_top
`default_nettype wire
